// ===== logic/trxcmd_pkg.sv
// Package of constants and types for the serial command port and RX polling control
package trxcmd_pkg;

   // ----------------------------------------------------------------
   // Command type codes (top three bits of the command byte)
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_RD_BUF  = 3'h0,
      CMD_WR_BUF  = 3'h1,
      CMD_RD_REG  = 3'h2,
      CMD_WR_REG  = 3'h3,
      CMD_OFF     = 3'h4,
      CMD_IRQ_CLR = 3'h5,
      CMD_UNUSED6 = 3'h6,
      CMD_UNUSED7 = 3'h7
   } trxcmd_code_type;

   // ----------------------------------------------------------------
   // Field positions and sizes
   // ----------------------------------------------------------------
   localparam int CMD_TYPE_MSB  = 7;
   localparam int CMD_TYPE_LSB  = 5;
   localparam int CMD_ADDR_MSB  = 4;
   localparam int BYTE_BITS     = 8;
   localparam int NUM_REGS      = 32;
   localparam int CFG_OPMODE_REG = 1;   // Register holding the two operating mode bits
   localparam int OPM_LOW_BIT   = 0;
   localparam int OPM_HIGH_BIT  = 1;
   localparam int SLEEP_REG     = 4;    // Register holding sleep field and extension bit
   localparam int SLEEP_LSB     = 0;
   localparam int SLEEP_XBIT    = 5;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ          = 50;
   localparam int SLEEP_UNIT       = 1024;  // Internal clock periods per sleep step
   localparam int SLEEP_XFACTOR    = 8;
   localparam int STARTUP_PLL_US   = 300;
   localparam int STARTUP_SIG_US   = 100;
   localparam int STARTUP_PLL_CYC  = STARTUP_PLL_US * CLK_MHZ;
   localparam int STARTUP_SIG_CYC  = STARTUP_SIG_US * CLK_MHZ;

   // Polling sequencer phases
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_SLEEP,
      PH_PLL,
      PH_SIG,
      PH_CHECK,
      PH_RECEIVE
   } trxcmd_phase_type;

   // Serial line outputs travel together
   typedef struct packed {
      logic dataOut;
      logic dataOutOeN;
   } trxcmd_sdo_type;

endpackage

// ===== logic/trxcmd_port.sv
// Serial command decoder with RX polling sequencer for the transceiver
// Contract
// R01 - Write-config stores single or consecutive registers
// R02 - Echo command and data bytes on output
// R03 - Power-off only when supply, wake, keys allow
// R04 - Interrupt-clear command drives interrupt low
// R05 - Command type from bits 7 to 5
// R06 - Low five bits address registers only
// R07 - Command codes as listed, 110/111 unused
// R08 - Bits move with serial clock both ways
// R09 - No transfers while reset output low
// R10 - Chip select low, no transparent: high-Z
// R11 - Chip select low, transparent: stream out
// R12 - Mode bits select polled or continuous receive
// R13 - Polled receive enables path periodically
// R14 - Loop sleep, start-up, bit check
// R15 - Failed bit check returns to sleep
// R16 - Stay active only on valid signal
// R17 - Continuous receive keeps receiver always on
// R18 - Polling state shown on activity pin
// R19 - Ignore data in sleep and start-up
// R20 - Transmitter preburst covers whole polling cycle
// R21 - Host should disable clock and supply
// R22 - Port held reset while chip select low
// R23 - Bytes shift most significant bit first
// R24 - Shift out buffer count during command
// R25 - Sleep is field times 1024 times 1 or 8
// R26 - Launch on falling, sample on rising
module trxcmd_port
   import trxcmd_pkg::*;
#(
   parameter int SLEEP_UNIT_P   = SLEEP_UNIT,
   parameter int PLL_CYC_P      = STARTUP_PLL_CYC,
   parameter int SIG_CYC_P      = STARTUP_SIG_CYC,
   parameter int DCLK_DIV       = 16
)
(
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              chipSelect,
   input  wire logic              serialClock,
   input  wire logic              serial_data_in_line,
   output logic                   serial_data_out_line,
   output logic                   serialOutEnN,
   input  wire logic              transparentMode,
   input  wire logic              resetOutN,
   input  wire logic              analog_supply_enable,
   input  wire logic              wake_input_pin,
   input  wire logic [4:0]        key_inputs,
   input  wire logic [7:0]        bufferCount,
   input  wire logic [7:0]        bufferReadData,
   input  wire logic              demodData,
   input  wire logic              bitCheckOk,
   input  wire logic              bitCheckFail,
   output logic                   rxActive,
   output logic                   rxPathEnable,
   output logic                   bitCheckEnable,
   output logic                   offRequest,
   output logic                   irqOut,
   input  wire logic              irqSet,
   output logic                   bufferReadPulse,
   output logic                   bufferWritePulse,
   output logic [7:0]             bufferWriteData,
   output logic [7:0]             op_select_bits
);
   import trxcmd_pkg::*;

   // Divider counter is 16 bits wide; every phase needs at least one cycle
   if (DCLK_DIV < 2 || DCLK_DIV > 65536 || SLEEP_UNIT_P < 1 || PLL_CYC_P < 1 || SIG_CYC_P < 1)
   begin : g_param_check
      $error("trxcmd_port: unsupported parameter value");
   end

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] csSync;
   logic [1:0] sckSync;
   logic [1:0] sdiSync;
   logic [1:0] demSync;
   logic [5:0] gateSync0;   // Wake pin and key pins, first stage
   logic [5:0] gateSync1;
   logic       sckLast_r;

   // Chip select, serial clock, data, demodulator, wake and key pins pass two flops before any logic looks at them
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         csSync  <= 2'h0;
         sckSync <= 2'h0;
         sdiSync <= 2'h0;
         demSync <= 2'h0;
         gateSync0 <= 6'h00;
         gateSync1 <= 6'h00;
      end
      else
      begin
         csSync  <= {csSync[0], chipSelect};
         sckSync <= {sckSync[0], serialClock};
         sdiSync <= {sdiSync[0], serial_data_in_line};
         demSync <= {demSync[0], demodData};
         gateSync0 <= {wake_input_pin, key_inputs};
         gateSync1 <= gateSync0;
      end
   end

   logic csOn;
   logic sckRise;
   logic sckFall;
   assign csOn    = csSync[1] & resetOutN;   // R09
   assign sckRise = sckSync[1] & ~sckLast_r;  // R26
   assign sckFall = ~sckSync[1] & sckLast_r;  // R26

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         sckLast_r <= 1'b0;
      else
         sckLast_r <= sckSync[1];
   end

   // ----------------------------------------------------------------
   // Serial shifter and command decoder
   // ----------------------------------------------------------------
   logic [7:0]            shiftIn_r;
   logic [7:0]            shiftOut_r;
   logic [2:0]            bitCnt_r;
   logic                  haveCmd_r;
   trxcmd_code_type       cmd_r;
   logic [4:0]            addr_r;
   logic [7:0]            cfgRegs_r [NUM_REGS];
   logic [7:0]            byteIn;
   logic                  byteDone;

   assign byteIn   = {shiftIn_r[6:0], sdiSync[1]};        // R23
   assign byteDone = csOn & sckRise & (bitCnt_r == 3'h7);

   // Port state is cleared while chip select is low
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         shiftIn_r <= 8'h00;
         bitCnt_r  <= 3'h0;
         haveCmd_r <= 1'b0;
         cmd_r     <= CMD_RD_BUF;
         addr_r    <= 5'h00;
      end
      else if (!csOn)
      begin
         shiftIn_r <= 8'h00;                              // R22
         bitCnt_r  <= 3'h0;
         haveCmd_r <= 1'b0;
         addr_r    <= 5'h00;
      end
      else if (sckRise)
      begin
         shiftIn_r <= byteIn;                             // R08
         bitCnt_r  <= bitCnt_r + 3'h1;
         if (byteDone && !haveCmd_r)
         begin
            haveCmd_r <= 1'b1;
            cmd_r     <= trxcmd_code_type'(byteIn[CMD_TYPE_MSB:CMD_TYPE_LSB]); // R05
            addr_r    <= byteIn[CMD_ADDR_MSB:0];          // R06
         end
         else if (byteDone && (cmd_r == CMD_WR_REG || cmd_r == CMD_RD_REG))
            addr_r <= addr_r + 5'h01;                     // R01
      end
   end

   // Output shifter: buffer count first, then echo or read data
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         shiftOut_r <= 8'h00;
      else if (!csOn)
         shiftOut_r <= bufferCount;                       // R24
      else if (byteDone)
      begin
         if (!haveCmd_r && byteIn[7:5] == CMD_RD_REG)
            shiftOut_r <= cfgRegs_r[byteIn[4:0]];
         else if (haveCmd_r && cmd_r == CMD_RD_REG)
            shiftOut_r <= cfgRegs_r[addr_r + 5'h01];
         else if ((!haveCmd_r && byteIn[7:5] == CMD_RD_BUF)
                  || (haveCmd_r && cmd_r == CMD_RD_BUF))
            shiftOut_r <= bufferReadData;
         else
            shiftOut_r <= byteIn;                         // R02
      end
      else if (sckFall && bitCnt_r != 3'h0)
         shiftOut_r <= {shiftOut_r[6:0], 1'b0};           // R23
   end

   // Configuration register writes, one byte per data unit
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++)
      begin : g_reg
         always_ff @(posedge ref_clk or posedge sys_rst)
         begin
            if (sys_rst)
               cfgRegs_r[gi] <= REG_RESET;
            else if (byteDone && haveCmd_r && cmd_r == CMD_WR_REG && addr_r == 5'(gi))
               cfgRegs_r[gi] <= byteIn;                   // R01
         end
      end
   endgenerate

   // Command side effects as one-cycle pulses
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         offRequest       <= 1'b0;
         bufferReadPulse  <= 1'b0;
         bufferWritePulse <= 1'b0;
         bufferWriteData  <= 8'h00;
      end
      else
      begin
         offRequest       <= byteDone && !haveCmd_r && byteIn[7:5] == CMD_OFF
                             && !analog_supply_enable && !gateSync1[5]
                             && (&gateSync1[4:0]);        // R03
         bufferReadPulse  <= byteDone && ((!haveCmd_r && byteIn[7:5] == CMD_RD_BUF)
                             || (haveCmd_r && cmd_r == CMD_RD_BUF));
         bufferWritePulse <= byteDone && haveCmd_r && cmd_r == CMD_WR_BUF;
         if (byteDone)
            bufferWriteData <= byteIn;
      end
   end

   // Interrupt: a set in the same cycle as the clear wins
   logic irqClr;
   assign irqClr = byteDone && !haveCmd_r && byteIn[7:5] == CMD_IRQ_CLR; // R07
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         irqOut <= 1'b0;
      else if (irqSet)
         irqOut <= 1'b1;
      else if (irqClr)
         irqOut <= 1'b0;                                  // R04
   end

   // Serial output pin: port data, transparent stream or released
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         serial_data_out_line <= 1'b0;
         serialOutEnN         <= 1'b1;
      end
      else if (csOn)
      begin
         serial_data_out_line <= shiftOut_r[7];           // R08
         serialOutEnN         <= 1'b0;
      end
      else if (transparentMode)
      begin
         serial_data_out_line <= demSync[1];              // R11
         serialOutEnN         <= 1'b0;
      end
      else
      begin
         serial_data_out_line <= 1'b0;
         serialOutEnN         <= 1'b1;                    // R10
      end
   end

   // ----------------------------------------------------------------
   // RX polling sequencer
   // ----------------------------------------------------------------
   logic [1:0]       opm;
   logic [4:0]       sleepField;
   logic             sleepExt;
   trxcmd_phase_type phase_r;
   logic [31:0]      phaseCnt_r;
   logic [31:0]      sleepCycles;
   logic [15:0]      divCnt_r;
   logic             dclkTick;

   assign opm        = {cfgRegs_r[CFG_OPMODE_REG][OPM_HIGH_BIT],
                        cfgRegs_r[CFG_OPMODE_REG][OPM_LOW_BIT]};
   assign sleepField = cfgRegs_r[SLEEP_REG][SLEEP_LSB +: 5];
   assign sleepExt   = cfgRegs_r[SLEEP_REG][SLEEP_XBIT];
   // Sleep length in internal clock periods
   assign sleepCycles = 32'(sleepField) * 32'(SLEEP_UNIT_P)
                        * (sleepExt ? 32'(SLEEP_XFACTOR) : 32'h1);     // R25
   assign dclkTick    = (divCnt_r == 16'(DCLK_DIV - 1));

   // Divider gives the internal clock rate as an enable pulse
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         divCnt_r <= 16'h0000;
      else if (dclkTick)
         divCnt_r <= 16'h0000;
      else
         divCnt_r <= divCnt_r + 16'h0001;
   end

   // Phase sequencing; bit-check verdicts only count in the check phase
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         phase_r    <= PH_IDLE;
         phaseCnt_r <= 32'h0;
      end
      else
      begin
         case (phase_r)
            PH_IDLE:
            begin
               phaseCnt_r <= 32'h0;
               if (opm == 2'h2)
                  phase_r <= PH_SLEEP;                    // R12
               else if (opm == 2'h3)
                  phase_r <= PH_PLL;                      // R17
            end
            PH_SLEEP:
            begin
               if (opm != 2'h2)
                  phase_r <= PH_IDLE;
               else if (phaseCnt_r >= sleepCycles)
               begin
                  phase_r    <= PH_PLL;                   // R14
                  phaseCnt_r <= 32'h0;
               end
               else if (dclkTick)
                  phaseCnt_r <= phaseCnt_r + 32'h1;
            end
            PH_PLL:
            begin
               if (opm[1] == 1'b0)
                  phase_r <= PH_IDLE;
               else if (phaseCnt_r >= 32'(PLL_CYC_P - 1))
               begin
                  phase_r    <= PH_SIG;                   // R14
                  phaseCnt_r <= 32'h0;
               end
               else
                  phaseCnt_r <= phaseCnt_r + 32'h1;
            end
            PH_SIG:
            begin
               if (opm[1] == 1'b0)
                  phase_r <= PH_IDLE;
               else if (phaseCnt_r >= 32'(SIG_CYC_P - 1))
               begin
                  phase_r    <= PH_CHECK;                 // R14
                  phaseCnt_r <= 32'h0;
               end
               else
                  phaseCnt_r <= phaseCnt_r + 32'h1;
            end
            PH_CHECK:
            begin
               phaseCnt_r <= 32'h0;
               if (opm[1] == 1'b0)
                  phase_r <= PH_IDLE;
               else if (bitCheckOk)
                  phase_r <= PH_RECEIVE;                  // R16
               else if (bitCheckFail && opm == 2'h2)
                  phase_r <= PH_SLEEP;                    // R15
            end
            PH_RECEIVE:
            begin
               if (opm[1] == 1'b0)
                  phase_r <= PH_IDLE;
            end
            default:
               phase_r <= PH_IDLE;
         endcase
      end
   end

   // Status pins follow the phase; receiver is off only while idle or asleep
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rxActive       <= 1'b0;
         rxPathEnable   <= 1'b0;
         bitCheckEnable <= 1'b0;
         op_select_bits <= 8'h00;
      end
      else
      begin
         rxActive       <= phase_r inside {PH_PLL, PH_SIG, PH_CHECK, PH_RECEIVE}; // R18
         rxPathEnable   <= phase_r inside {PH_PLL, PH_SIG, PH_CHECK, PH_RECEIVE}; // R13
         bitCheckEnable <= (phase_r == PH_CHECK);         // R19
         op_select_bits <= cfgRegs_r[CFG_OPMODE_REG];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_checkFail;
      phase_r == PH_CHECK && bitCheckFail && !bitCheckOk && opm == 2'h2;
   endsequence

   chk_fail_to_sleep: assert property (@(posedge ref_clk) disable iff (sys_rst) // R15
      s_checkFail |=> phase_r == PH_SLEEP)
      else $error("failed check did not return to sleep");

   chk_hiz_when_idle: assert property (@(posedge ref_clk) disable iff (sys_rst) // R10
      !csOn && !transparentMode |=> serialOutEnN)
      else $error("serial output driven while deselected");

   chk_transparent_out: assert property (@(posedge ref_clk) disable iff (sys_rst) // R11
      !csOn && transparentMode |=> !serialOutEnN && serial_data_out_line == $past(demSync[1]))
      else $error("transparent stream not on output");

   chk_irq_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // R04
      irqClr && !irqSet |=> !irqOut)
      else $error("interrupt not cleared");

   chk_off_gate: assert property (@(posedge ref_clk) disable iff (sys_rst) // R03
      offRequest |-> $past(!analog_supply_enable && !gateSync1[5] && (&gateSync1[4:0])))
      else $error("power-off despite blocking inputs");

   chk_port_reset: assert property (@(posedge ref_clk) disable iff (sys_rst) // R22
      !csOn |=> bitCnt_r == 3'h0 && !haveCmd_r)
      else $error("port not held in reset");

   chk_active_pin: assert property (@(posedge ref_clk) disable iff (sys_rst) // R18
      phase_r == PH_SLEEP ##1 phase_r == PH_SLEEP |-> !rxActive)
      else $error("activity pin high while asleep");

   chk_cont_never_sleep: assert property (@(posedge ref_clk) disable iff (sys_rst) // R17
      opm == 2'h3 && phase_r != PH_IDLE |=> phase_r != PH_SLEEP)
      else $error("continuous receive went to sleep");

   chk_wr_store: assert property (@(posedge ref_clk) disable iff (sys_rst) // R01
      byteDone && haveCmd_r && cmd_r == CMD_WR_REG |=> cfgRegs_r[$past(addr_r)] == $past(byteIn))
      else $error("configuration byte not stored");

endmodule

// ===== tb/trxcmd_host.sv
// Host controller model that drives the serial command port
module trxcmd_host
(
   input  wire logic ref_clk,
   input  wire logic serial_data_out_line,
   output logic      chipSelect,
   output logic      serialClock,
   output logic      serial_data_in_line
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Idle state: deselected, serial clock parked low
   // ----------------------------------------------------------------
   initial
   begin
      chipSelect = 1'b0;
      serialClock = 1'b0;
      serial_data_in_line = 1'b0;
   end

   // Select, then give the port synchroniser time to settle
   task automatic frameOpen();
      @(posedge ref_clk);
      chipSelect <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask

   // Deselect; data line flips so a stale bit never looks driven
   task automatic frameClose();
      @(posedge ref_clk);
      chipSelect <= 1'b0;
      serial_data_in_line <= ~serial_data_in_line;
      repeat (8) @(posedge ref_clk);
   endtask

   // Launch after the falling edge, sample late in the high phase (160 ns period)
   task automatic shiftBits(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nBits; i--)
      begin
         @(posedge ref_clk);
         serial_data_in_line <= tx[i];
         repeat (3) @(posedge ref_clk);
         serialClock <= 1'b1;
         repeat (3) @(posedge ref_clk);
         @(negedge ref_clk);
         rx[i] = serial_data_out_line;
         @(posedge ref_clk);
         serialClock <= 1'b0;
      end
   endtask
endmodule

// ===== tb/trxcmd_port_tb.sv
// Self-checking testbench for the serial command port and RX polling control
module trxcmd_port_tb;
   import trxcmd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'b0, sys_rst = 1'b1, sdo, sdoEnN, transparentMode = 1'b0;
   logic resetOutN = 1'b1, anaEn = 1'b0, wake = 1'b0, demodData = 1'b0;
   logic chkOk = 1'b0, chkFail = 1'b0, irqSet = 1'b0, cs, sclk, sdi;
   logic [4:0] keys = 5'h1F;
   logic rxActive, rxPathEnable, bitCheckEnable, offRequest, irqOut, rdPulse, wrPulse;
   logic [7:0] wrData, opBits, r0, r1, r2;
   int bad_count = 0, samples_checked = 0, offCnt = 0, rdCnt = 0, wrCnt = 0, n, s;
   localparam int DIV = 16;  // Internal clock divider handed to the design

   // ----------------------------------------------------------------
   // Clock, design and host model
   // ----------------------------------------------------------------
   always #10 ref_clk = ~ref_clk;

   trxcmd_port #(.SLEEP_UNIT_P(4), .PLL_CYC_P(4), .SIG_CYC_P(4), .DCLK_DIV(DIV)) u_trxcmd_port (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .chipSelect(cs), .serialClock(sclk),
      .serial_data_in_line(sdi), .serial_data_out_line(sdo), .serialOutEnN(sdoEnN),
      .transparentMode(transparentMode), .resetOutN(resetOutN),
      .analog_supply_enable(anaEn), .wake_input_pin(wake), .key_inputs(keys),
      .bufferCount(8'hA5), .bufferReadData(8'h3C), .demodData(demodData),
      .bitCheckOk(chkOk), .bitCheckFail(chkFail), .rxActive(rxActive),
      .rxPathEnable(rxPathEnable), .bitCheckEnable(bitCheckEnable),
      .offRequest(offRequest), .irqOut(irqOut), .irqSet(irqSet),
      .bufferReadPulse(rdPulse), .bufferWritePulse(wrPulse),
      .bufferWriteData(wrData), .op_select_bits(opBits));

   trxcmd_host u_trxcmd_host (.ref_clk(ref_clk), .serial_data_out_line(sdo),
      .chipSelect(cs), .serialClock(sclk), .serial_data_in_line(sdi));

   // One-cycle pulses are tallied so a frame can be judged afterwards
   always @(posedge ref_clk)
   begin
      offCnt <= offCnt + int'(offRequest === 1'b1);
      rdCnt <= rdCnt + int'(rdPulse === 1'b1);
      wrCnt <= wrCnt + int'(wrPulse === 1'b1);
   end

   // ----------------------------------------------------------------
   // Compare, access and wait tasks
   // ----------------------------------------------------------------
   task automatic chk1(input logic got, input logic exp, input string msg);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %b", $time, msg, got);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   // Whole frame: command then up to two data bytes; returns what came back
   task automatic doFrame(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1,
                          input int nData);
      u_trxcmd_host.frameOpen();
      u_trxcmd_host.shiftBits(c, 8, r0);
      if (nData > 0) u_trxcmd_host.shiftBits(d0, 8, r1);
      if (nData > 1) u_trxcmd_host.shiftBits(d1, 8, r2);
      u_trxcmd_host.frameClose();
   endtask

   // Cycles until rxActive (sel 0) or bitCheckEnable (sel 1) reaches val
   task automatic waitSig(input bit sel, input logic val);
      n = 0;
      while (((sel ? bitCheckEnable : rxActive) !== val) && n < 3000)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 3000) chk1(1'b0, 1'b1, "wait timed out");
   endtask

   task automatic pulseIn(input bit ok);
      @(posedge ref_clk);
      if (ok) chkOk <= 1'b1;
      else chkFail <= 1'b1;
      @(posedge ref_clk);
      chkOk <= 1'b0;
      chkFail <= 1'b0;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog sized well above the whole sequence
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      chk1(sdoEnN, 1'b1, "released after reset");
      chk1(rxActive, 1'b0, "idle after reset");
      repeat (3) @(posedge ref_clk);
      // Run write from register 0; count out first, then echoes
      doFrame(8'h60, 8'h11, 8'h5C, 2);
      chk8(r0, 8'hA5, "count during command");
      chk8(r1, 8'h60, "command echo");
      chk8(r2, 8'h11, "data echo");
      chk8(opBits, 8'h5C, "run write");
      // Run read from register 0 returns what the write stored
      doFrame(8'h40, 8'h00, 8'h00, 2);
      chk8(r1, 8'h11, "read first register");
      chk8(r2, 8'h5C, "read next register");
      // Deselect mid-byte, then a frame while reset output low
      u_trxcmd_host.frameOpen();
      u_trxcmd_host.shiftBits(8'h61, 8, r0);
      u_trxcmd_host.shiftBits(8'hFF, 4, r1);
      u_trxcmd_host.frameClose();
      chk8(opBits, 8'h5C, "partial byte dropped");
      resetOutN <= 1'b0;
      doFrame(8'h61, 8'hFF, 8'h00, 1);
      resetOutN <= 1'b1;
      chk8(opBits, 8'h5C, "blocked by reset output");
      // Interrupt clear and unused codes
      pulseIn(1'b0);
      @(posedge ref_clk);
      irqSet <= 1'b1;
      @(posedge ref_clk);
      irqSet <= 1'b0;
      doFrame(8'hC0, 8'h00, 8'h00, 0);
      doFrame(8'hE0, 8'h00, 8'h00, 0);
      chk1(irqOut, 1'b1, "unused codes act");
      chk8(opBits, 8'h5C, "unused codes write");
      doFrame(8'hA0, 8'h00, 8'h00, 0);
      chk1(irqOut, 1'b0, "interrupt clear");
      // Power-off: allowed once, then each blocking condition in turn
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk);
         anaEn <= (i == 1);
         wake <= (i == 2);
         keys <= (i == 3) ? 5'h1E : 5'h1F;
         doFrame(8'h80, 8'h00, 8'h00, 0);
         chk8(8'(offCnt), 8'h01, "power-off gating");
      end
      // Buffer commands
      doFrame(8'h00, 8'h00, 8'h00, 1);
      chk1(rdCnt == 2, 1'b1, "buffer read");
      chk8(r1, 8'h3C, "buffer read data");
      doFrame(8'h20, 8'h3C, 8'h00, 1);
      chk1(wrCnt == 1, 1'b1, "buffer write");
      chk8(wrData, 8'h3C, "buffer write data");
      // Transparent stream while deselected
      transparentMode <= 1'b1;
      demodData <= 1'b1;
      repeat (6) @(negedge ref_clk);
      chk1(sdoEnN, 1'b0, "transparent drive");
      chk1(sdo, 1'b1, "stream high");
      @(posedge ref_clk);
      demodData <= 1'b0;
      repeat (6) @(negedge ref_clk);
      chk1(sdo, 1'b0, "stream low");
      @(posedge ref_clk);
      transparentMode <= 1'b0;
      repeat (6) @(negedge ref_clk);
      chk1(sdoEnN, 1'b1, "released again");
      // Polled receive: sleep 2 units, plain then extended
      for (int x = 0; x < 2; x++)
      begin
         doFrame(8'h64, {2'b00, x[0], 5'h02}, 8'h00, 1);
         // Polling entered with the host's clock and supply requests left off
         doFrame(8'h61, 8'h02, 8'h00, 1);
         waitSig(1'b1, 1'b1);
         chk1(rxActive, 1'b1, "active in check");
         pulseIn(1'b0);
         waitSig(1'b0, 1'b0);
         waitSig(1'b0, 1'b1);
         // Field 2 times unit 4 ticks, each tick DIV cycles; divider phase adds jitter
         s = 2 * 4 * (x ? SLEEP_XFACTOR : 1) * DIV;
         chk1(n >= s - DIV && n <= s + 2, 1'b1, "sleep length");
         waitSig(1'b1, 1'b1);
         chk1(n >= 8 && n <= 10, 1'b1, "start-up length");
      end
      // Preburst outlasts the whole cycle, so the valid verdict lands in check
      pulseIn(1'b1);
      repeat (100) @(negedge ref_clk);
      chk1(rxActive, 1'b1, "stays active");
      chk1(bitCheckEnable, 1'b0, "receiving");
      // Continuous receive survives a failed check
      doFrame(8'h61, 8'h00, 8'h00, 1);
      doFrame(8'h61, 8'h03, 8'h00, 1);
      waitSig(1'b1, 1'b1);
      pulseIn(1'b0);
      repeat (20) @(negedge ref_clk);
      chk1(rxPathEnable, 1'b1, "continuous path");
      chk1(bitCheckEnable, 1'b1, "continuous check");
      conclude();
   end
endmodule
